/* File: src/irq_prio_ctrl.sv */
// interrupt enable, four-level priority and vector selection with wishbone registers
`timescale 1ns/1ps
module irq_prio_ctrl (
  input wire logic CLK, // system clock, 20 MHz
  input wire logic RST_B, // async reset, active low
  input wire logic [11:0] ADR_I, // wishbone byte address
  input wire logic [31:0] DAT_I, // wishbone write data
  output logic [31:0] DAT_O, // wishbone read data
  input wire logic WE_I, // wishbone write
  input wire logic [3:0] SEL_I, // wishbone byte lanes
  input wire logic CYC_I, // wishbone cycle
  input wire logic STB_I, // wishbone strobe
  output logic ACK_O, // wishbone acknowledge
  input wire logic EXT0_FLAG, // external interrupt 0 request
  input wire logic EXT1_FLAG, // external interrupt 1 request
  input wire logic TIMER0_OVF, // timer 0 overflow request
  input wire logic TIMER1_OVF, // timer 1 overflow request
  input wire logic TIMER2_FLAG, // timer 2 request
  input wire logic UART_RX_FLAG, // uart receive flag
  input wire logic UART_TX_FLAG, // uart transmit flag
  input wire logic SPI_DONE_FLAG, // spi transfer done flag
  input wire logic CORE_ACK, // core takes the vector, pulse
  input wire logic CORE_RETI, // core ends a service routine, pulse
  output logic IRQ_REQ, // request to the core, level
  output logic [15:0] IRQ_VECTOR, // vector address for the core
  output logic [1:0] IRQ_LEVEL, // level of the pending request
  output logic IRQ_OUT // event interrupt, level
);

  // ************************************
  // register file
  // ************************************
  logic [7:0] interrupt_enable_mask;
  logic [7:0] priority_high_reg;
  logic [7:0] priority_low_reg;
  logic [5:0] evt_status_reg;
  logic [5:0] evt_mask_reg;
  logic [3:0] in_service_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic req_reg;
  logic [15:0] vector_reg;
  logic [1:0] level_reg;
  logic [2:0] src_reg;
  logic irq_reg;

  logic bus_req;
  logic bus_wr;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;
  logic [5:0] raw_req;
  logic [5:0] live_req;
  logic win_valid;
  logic [2:0] win_src;
  logic [1:0] win_level;
  logic [15:0] win_vector;
  logic [2:0] cur_level;
  logic cur_busy;
  logic preempt_ok;
  logic [3:0] in_service_next;
  logic [5:0] evt_status_next;

  // 0 none, 1 enable, 2 prio high, 3 prio low, 4 status, 5 mask, 6 state
  function automatic logic [2:0] reg_sel(input logic [11:0] adr);
    if (adr == irq_prio_pkg::ADR_ENABLE) begin
      reg_sel = 3'h1;
    end else if (adr == irq_prio_pkg::ADR_PRIO_HIGH) begin
      reg_sel = 3'h2;
    end else if (adr == irq_prio_pkg::ADR_PRIO_LOW) begin
      reg_sel = 3'h3;
    end else if (adr == irq_prio_pkg::ADR_EVT_STATUS) begin
      reg_sel = 3'h4;
    end else if (adr == irq_prio_pkg::ADR_EVT_MASK) begin
      reg_sel = 3'h5;
    end else if (adr == irq_prio_pkg::ADR_STATE) begin
      reg_sel = 3'h6;
    end else begin
      reg_sel = 3'h0;
    end
  endfunction

  function automatic logic [15:0] slot_vector(input logic [2:0] s);
    case (s)
      3'h0: slot_vector = irq_prio_pkg::VEC_EXT0;
      3'h1: slot_vector = irq_prio_pkg::VEC_TIMER0;
      3'h2: slot_vector = irq_prio_pkg::VEC_EXT1;
      3'h3: slot_vector = irq_prio_pkg::VEC_TIMER1;
      3'h4: slot_vector = irq_prio_pkg::VEC_SERIAL;
      default: slot_vector = irq_prio_pkg::VEC_TIMER2;
    endcase
  endfunction

  // ************************************
  // wishbone slave
  // ************************************
  assign bus_req = CYC_I && STB_I;
  // a write lands on the edge where the master sees ack high
  assign bus_wr = bus_req && WE_I && ack_reg && SEL_I[0];
  assign wr_sel = reg_sel(ADR_I);
  assign rd_sel = reg_sel(ADR_I);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req && !ack_reg;
    end
  end

  // unmapped addresses are acknowledged and read as zero
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      dat_reg <= 32'h0000_0000;
    end else if (bus_req && !ack_reg) begin
      case (rd_sel)
        3'h1: dat_reg <= {24'h0, interrupt_enable_mask};
        3'h2: dat_reg <= {26'h0, priority_high_reg[5:0]};
        3'h3: dat_reg <= {26'h0, priority_low_reg[5:0]};
        3'h4: dat_reg <= {26'h0, evt_status_reg};
        3'h5: dat_reg <= {26'h0, evt_mask_reg};
        3'h6: dat_reg <= {22'h0, raw_req, in_service_reg};
        default: dat_reg <= 32'h0000_0000;
      endcase
    end
  end

  // reserved bits are stored as zero whatever is written
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      interrupt_enable_mask <= irq_prio_pkg::ENABLE_RESET;
    end else if (bus_wr && wr_sel == 3'h1) begin
      interrupt_enable_mask <= DAT_I[7:0] & 8'hBF;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      priority_high_reg <= irq_prio_pkg::PRIO_HIGH_RESET;
    end else if (bus_wr && wr_sel == 3'h2) begin
      priority_high_reg <= {2'h0, DAT_I[5:0]};
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      priority_low_reg <= irq_prio_pkg::PRIO_LOW_RESET;
    end else if (bus_wr && wr_sel == 3'h3) begin
      priority_low_reg <= {2'h0, DAT_I[5:0]};
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      evt_mask_reg <= 6'h00;
    end else if (bus_wr && wr_sel == 3'h5) begin
      evt_mask_reg <= DAT_I[5:0];
    end
  end

  // ************************************
  // request gathering and arbitration
  // ************************************
  assign raw_req[irq_prio_pkg::SLOT_EXT0] = EXT0_FLAG;
  assign raw_req[irq_prio_pkg::SLOT_TIMER0] = TIMER0_OVF;
  assign raw_req[irq_prio_pkg::SLOT_EXT1] = EXT1_FLAG;
  assign raw_req[irq_prio_pkg::SLOT_TIMER1] = TIMER1_OVF;
  // the handler must poll the three flags to find the cause
  assign raw_req[irq_prio_pkg::SLOT_SERIAL] =
    UART_RX_FLAG || UART_TX_FLAG || SPI_DONE_FLAG;
  assign raw_req[irq_prio_pkg::SLOT_TIMER2] = TIMER2_FLAG;

  // enable bits follow slot order, so slot n is gated by enable bit n
  always_comb begin
    live_req = 6'h00;
    if (interrupt_enable_mask[irq_prio_pkg::BIT_GLOBAL_EN]) begin
      live_req[0] = raw_req[0] && interrupt_enable_mask[irq_prio_pkg::BIT_EXT0];
      live_req[1] = raw_req[1] && interrupt_enable_mask[irq_prio_pkg::BIT_TIMER0];
      live_req[2] = raw_req[2] && interrupt_enable_mask[irq_prio_pkg::BIT_EXT1];
      live_req[3] = raw_req[3] && interrupt_enable_mask[irq_prio_pkg::BIT_TIMER1];
      live_req[4] = raw_req[4] && interrupt_enable_mask[irq_prio_pkg::BIT_SERIAL];
      live_req[5] = raw_req[5] && interrupt_enable_mask[irq_prio_pkg::BIT_TIMER2];
    end
  end

  logic [1:0] slot_level [6];

  // slot to register bit: ext0 0, timer0 1, ext1 2, timer1 3, serial 4, timer2 5
  localparam logic [17:0] SLOT_POS = 18'h2C688;
  genvar g;
  generate
    for (g = 0; g < irq_prio_pkg::NSRC; g++) begin : g_lvl
      assign slot_level[g] = {priority_high_reg[SLOT_POS[3*g +: 3]],
                              priority_low_reg[SLOT_POS[3*g +: 3]]};
    end
  endgenerate

  // highest level first, lowest vector wins a tie
  always_comb begin
    win_valid = 1'b0;
    win_src = 3'h0;
    win_level = 2'h0;
    for (int l = 3; l >= 0; l--) begin
      for (int s = 0; s < irq_prio_pkg::NSRC; s++) begin
        if (!win_valid && live_req[s] && slot_level[s] == 2'(l)) begin
          win_valid = 1'b1;
          win_src = 3'(s);
          win_level = 2'(l);
        end
      end
    end
  end

  assign win_vector = slot_vector(win_src);

  always_comb begin
    cur_busy = |in_service_reg;
    cur_level = 3'h0;
    for (int l = 0; l < 4; l++) begin
      if (in_service_reg[l]) begin
        cur_level = 3'(l);
      end
    end
  end

  // only a strictly higher level may interrupt a running service
  assign preempt_ok = !cur_busy || ({1'b0, win_level} > cur_level);

  // ************************************
  // core handshake
  // ************************************
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      req_reg <= 1'b0;
      vector_reg <= irq_prio_pkg::VEC_RESET;
      level_reg <= 2'h0;
      src_reg <= 3'h0;
    end else if (CORE_ACK && req_reg) begin
      req_reg <= 1'b0;
    end else begin
      req_reg <= win_valid && preempt_ok;
      if (win_valid && preempt_ok) begin
        vector_reg <= win_vector;
        level_reg <= win_level;
        src_reg <= win_src;
      end
    end
  end

  // reti retires the top level; a same-cycle ack then adds its own
  always_comb begin
    in_service_next = in_service_reg;
    if (CORE_RETI && cur_busy) begin
      in_service_next[cur_level[1:0]] = 1'b0;
    end
    if (CORE_ACK && req_reg) begin
      in_service_next[level_reg] = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      in_service_reg <= 4'h0;
    end else begin
      in_service_reg <= in_service_next;
    end
  end

  // ************************************
  // event status and interrupt line
  // ************************************
  // a vector taken on the clearing cycle keeps its bit set
  always_comb begin
    evt_status_next = evt_status_reg;
    if (bus_wr && wr_sel == 3'h4) begin
      evt_status_next = evt_status_reg & ~DAT_I[5:0];
    end
    if (CORE_ACK && req_reg) begin
      evt_status_next[src_reg] = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      evt_status_reg <= 6'h00;
      irq_reg <= 1'b0;
    end else begin
      evt_status_reg <= evt_status_next;
      irq_reg <= |(evt_status_next & evt_mask_reg);
    end
  end

  assign DAT_O = dat_reg;
  assign ACK_O = ack_reg;
  assign IRQ_REQ = req_reg;
  assign IRQ_VECTOR = vector_reg;
  assign IRQ_LEVEL = level_reg;
  assign IRQ_OUT = irq_reg;

  // ************************************
  // assertions
  // ************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  reset_vector_a: assert property (
    $rose(RST_B) |-> IRQ_VECTOR == 16'h0000 && !IRQ_REQ)
    else $error("vector not 0000H after reset");

  ext_vectors_a: assert property (
    IRQ_REQ && src_reg == 3'h0 |-> IRQ_VECTOR == 16'h0003)
    else $error("external 0 vector wrong");

  ext1_vector_a: assert property (
    IRQ_REQ && src_reg == 3'h2 |-> IRQ_VECTOR == 16'h0013)
    else $error("external 1 vector wrong");

  timer_vectors_a: assert property (
    IRQ_REQ && src_reg inside {3'h1, 3'h3} |->
      IRQ_VECTOR == (src_reg == 3'h1 ? 16'h000B : 16'h001B))
    else $error("timer vector wrong");

  serial_merge_a: assert property (
    IRQ_REQ && IRQ_VECTOR == 16'h0023 |->
      $past(UART_RX_FLAG || UART_TX_FLAG || SPI_DONE_FLAG))
    else $error("serial vector without a serial flag");

  global_off_a: assert property (
    !$past(interrupt_enable_mask[7]) && !$past(IRQ_REQ) |-> !IRQ_REQ)
    else $error("request while globally disabled");

  source_enable_a: assert property (
    IRQ_REQ && !$past(IRQ_REQ) |->
      |($past(interrupt_enable_mask[5:0]) & (6'h01 << SLOT_POS[3*src_reg +: 3])))
    else $error("request from a disabled source");

  serial_enable_a: assert property (
    IRQ_REQ && !$past(IRQ_REQ) && src_reg == 3'h4 |-> $past(interrupt_enable_mask[4]))
    else $error("serial request with serial enable clear");

  ext_enable_a: assert property (
    IRQ_REQ && !$past(IRQ_REQ) && src_reg == 3'h2 |-> $past(interrupt_enable_mask[2]))
    else $error("external 1 request with its enable clear");

  prio_unused_a: assert property (
    priority_low_reg[7:6] == 2'h0 && priority_high_reg[7:6] == 2'h0)
    else $error("unused priority bits set");

  preempt_level_a: assert property (
    $rose(IRQ_REQ) && $past(cur_busy) |-> {1'b0, IRQ_LEVEL} > $past(cur_level))
    else $error("request does not outrank running service");

  ack_one_cycle_a: assert property (
    ACK_O |=> !ACK_O)
    else $error("bus ack held two cycles");

  preempt_c: cover property (cur_busy && $rose(IRQ_REQ));
  serial_c: cover property (IRQ_REQ && IRQ_VECTOR == 16'h0023 ##1 CORE_ACK);
  nest_c: cover property (in_service_reg[3] && in_service_reg[0]);
  set_clear_c: cover property (CORE_ACK && req_reg && bus_wr && wr_sel == 3'h4);

endmodule

/* File: src/irq_prio_pkg.sv */
// constants, register map and types of the interrupt enable and priority block
//
// Overview of operation
// - reset vector is 0000H, pin or power-on
// - external 0 to 0003H, external 1 to 0013H
// - timer 0 to 000BH, timer 1 to 001BH
// - uart and spi flags share vector 0023H
// - global enable bit 7 gates every source
// - enables: timer2 bit5, timer1 bit3, timer0 bit1
// - one serial enable, bit 4, for both
// - external 1 enable bit2, external 0 bit0
// - low priority bits 5..0, bits 7..6 unused
// - high priority bits use same layout
// - timer 2 low priority sits at bit 5
package irq_prio_pkg;

  // ************************************
  // register indices and byte addresses
  // ************************************
  localparam logic [7:0] IDX_ENABLE = 8'hA8;
  localparam logic [7:0] IDX_PRIO_HIGH = 8'hB7;
  localparam logic [7:0] IDX_PRIO_LOW = 8'hB8;
  localparam logic [7:0] IDX_EVT_STATUS = 8'hC0;
  localparam logic [7:0] IDX_EVT_MASK = 8'hC1;
  localparam logic [7:0] IDX_STATE = 8'hC2;
  localparam logic [11:0] ADR_ENABLE = {2'h0, IDX_ENABLE, 2'h0};
  localparam logic [11:0] ADR_PRIO_HIGH = {2'h0, IDX_PRIO_HIGH, 2'h0};
  localparam logic [11:0] ADR_PRIO_LOW = {2'h0, IDX_PRIO_LOW, 2'h0};
  localparam logic [11:0] ADR_EVT_STATUS = {2'h0, IDX_EVT_STATUS, 2'h0};
  localparam logic [11:0] ADR_EVT_MASK = {2'h0, IDX_EVT_MASK, 2'h0};
  localparam logic [11:0] ADR_STATE = {2'h0, IDX_STATE, 2'h0};

  // ************************************
  // field positions and reset values
  // ************************************
  localparam int NSRC = 6;
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_RESERVED = 6;
  localparam int BIT_TIMER2 = 5;
  localparam int BIT_SERIAL = 4;
  localparam int BIT_TIMER1 = 3;
  localparam int BIT_EXT1 = 2;
  localparam int BIT_TIMER0 = 1;
  localparam int BIT_EXT0 = 0;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] PRIO_HIGH_RESET = 8'h00;
  localparam logic [7:0] PRIO_LOW_RESET = 8'h00;
  localparam logic [5:0] SRC_FIELD_MASK = 6'h3F;

  // ************************************
  // vectors
  // ************************************
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_TIMER0 = 16'h000B;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_TIMER1 = 16'h001B;
  localparam logic [15:0] VEC_SERIAL = 16'h0023;
  localparam logic [15:0] VEC_TIMER2 = 16'h002B;

  // source slots in ascending vector order, which is also tie order
  typedef enum {SLOT_EXT0, SLOT_TIMER0, SLOT_EXT1, SLOT_TIMER1, SLOT_SERIAL,
                SLOT_TIMER2} slot_t;

endpackage

/* File: tb/core_model.sv */
// processor core model that takes interrupt vectors and returns from service
`timescale 1ns/1ps
module core_model (
  input wire logic clk, // system clock
  input wire logic rst_b, // reset, active low
  input wire logic irq_req, // vector request from the block
  input wire logic [15:0] irq_vector, // offered vector
  input wire logic ack_en, // core willing to take vectors; low stalls it
  input wire logic reti_go, // one-cycle command to end a service
  output logic core_ack, // take pulse
  output logic core_reti, // return pulse
  output logic [15:0] taken_vec, // last vector taken
  output int taken_cnt // vectors taken so far
);
  // ****************
  // take and return
  // ****************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_ack <= 1'b0;
      core_reti <= 1'b0;
      taken_vec <= 16'hFFFF;
      taken_cnt <= 0;
    end else begin
      // never two pulses in a row: the request only drops one cycle after the take
      core_ack <= ack_en && irq_req && !core_ack;
      core_reti <= reti_go;
      if (core_ack && irq_req) begin
        taken_vec <= irq_vector;
        taken_cnt <= taken_cnt + 1;
      end
    end
  end
endmodule

/* File: tb/test_interrupt_enable_priority.sv */
// self-checking bench of the interrupt enable and priority block
`timescale 1ns/1ps
module test_interrupt_enable_priority;
  localparam logic [11:0] A_EN = irq_prio_pkg::ADR_ENABLE;
  localparam logic [11:0] A_PH = irq_prio_pkg::ADR_PRIO_HIGH;
  localparam logic [11:0] A_PL = irq_prio_pkg::ADR_PRIO_LOW;
  localparam logic [11:0] A_ST = irq_prio_pkg::ADR_EVT_STATUS;
  localparam logic [11:0] A_MK = irq_prio_pkg::ADR_EVT_MASK;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [3:0] sel = 4'h1;
  logic ack;
  logic [7:0] flags = 8'h00;
  logic ack_en = 1'b0;
  logic reti_go = 1'b0;
  logic core_ack, core_reti, irq_req, irq_out;
  logic [15:0] irq_vector, taken_vec;
  logic [1:0] irq_level;
  logic [7:0] rd;
  int taken_cnt;
  int num_errors = 0;
  int tests_run = 0;
  always #25 clk = ~clk;
  // flags in slot order; uart tx and spi done sit at 6 and 7
  irq_prio_ctrl irq_prio_ctrl_inst (.CLK(clk), .RST_B(rst_b), .ADR_I(adr), .DAT_I(dat_w),
    .DAT_O(dat_r), .WE_I(we), .SEL_I(sel), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack),
    .EXT0_FLAG(flags[0]), .TIMER0_OVF(flags[1]), .EXT1_FLAG(flags[2]), .TIMER1_OVF(flags[3]),
    .UART_RX_FLAG(flags[4]), .TIMER2_FLAG(flags[5]), .UART_TX_FLAG(flags[6]),
    .SPI_DONE_FLAG(flags[7]), .CORE_ACK(core_ack), .CORE_RETI(core_reti),
    .IRQ_REQ(irq_req), .IRQ_VECTOR(irq_vector), .IRQ_LEVEL(irq_level), .IRQ_OUT(irq_out));
  core_model core_model_inst (.clk(clk), .rst_b(rst_b), .irq_req(irq_req),
    .irq_vector(irq_vector), .ack_en(ack_en), .reti_go(reti_go), .core_ack(core_ack),
    .core_reti(core_reti), .taken_vec(taken_vec), .taken_cnt(taken_cnt));
  // ****************
  // helpers
  // ****************
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wb(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    dat_w <= {24'h000000, d};
    n = 0;
    // ack and read data are taken as sampled at the rising edge itself
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("bus ack", 16'h0001, {15'h0000, ack});
    rd = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task rchk(input string nm, input logic [11:0] a, input logic [7:0] exp);
    wb(a, 1'b0, 8'h00);
    chk(nm, {8'h00, exp}, {8'h00, rd});
  endtask
  task setf(input logic [7:0] f);
    @(posedge clk);
    flags <= f;
  endtask
  task take(input logic [15:0] v);
    int c;
    int n;
    c = taken_cnt;
    n = 0;
    while (taken_cnt == c && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("vector taken", v, taken_vec);
    chk("take count", 16'(c + 1), 16'(taken_cnt));
  endtask
  task no_req;
    int c;
    c = taken_cnt;
    repeat (4) @(negedge clk);
    chk("no take", 16'(c), 16'(taken_cnt));
    chk("no request", 16'h0000, {15'h0000, irq_req});
  endtask
  task reti;
    @(posedge clk);
    reti_go <= 1'b1;
    @(posedge clk);
    reti_go <= 1'b0;
  endtask
  task offer(input logic [15:0] v, input logic [1:0] l);
    repeat (2) @(negedge clk);
    chk("offered request", 16'h0001, {15'h0000, irq_req});
    chk("offered vector", v, irq_vector);
    chk("offered level", {14'h0000, l}, {14'h0000, irq_level});
  endtask
  // ****************
  // scenarios
  // ****************
  task t_reset;
    chk("reset vector", 16'h0000, irq_vector);
    rchk("enable reset", A_EN, 8'h00);
    rchk("prio high reset", A_PH, 8'h00);
    rchk("prio low reset", A_PL, 8'h00);
  endtask
  task t_regs;
    wb(A_EN, 1'b1, 8'hBF);
    rchk("enable reserved", A_EN, 8'hBF);
    sel <= 4'hE;
    wb(A_EN, 1'b1, 8'h00);
    rchk("lane 0 off", A_EN, 8'hBF);
    sel <= 4'h1;
    wb(A_PH, 1'b1, 8'h3F);
    rchk("prio high used", A_PH, 8'h3F);
    wb(A_PL, 1'b1, 8'h3F);
    rchk("prio low used", A_PL, 8'h3F);
    wb(A_PH, 1'b1, 8'h00);
    wb(A_PL, 1'b1, 8'h00);
    wb(12'h7FC, 1'b1, 8'h55);
    rchk("unmapped", 12'h7FC, 8'h00);
  endtask
  task t_gate;
    ack_en <= 1'b1;
    wb(A_EN, 1'b1, 8'h3F);
    setf(8'hFF);
    no_req();
    wb(A_EN, 1'b1, 8'h80);
    no_req();
    setf(8'h00);
  endtask
  task t_vectors;
    static logic [15:0] vec [8] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
                                    16'h002B, 16'h0023, 16'h0023};
    static int eb [8] = '{0, 1, 2, 3, 4, 5, 4, 4};
    logic [7:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << eb[i];
      // every enable set except the source's own bit
      wb(A_EN, 1'b1, 8'h80 | (8'h3F & ~m));
      setf(8'h01 << i);
      no_req();
      wb(A_EN, 1'b1, 8'h80 | m);
      take(vec[i]);
      setf(8'h00);
      reti();
    end
  endtask
  task t_prio;
    ack_en <= 1'b0;
    wb(A_EN, 1'b1, 8'hBF);
    wb(A_PL, 1'b1, 8'h08);
    wb(A_PH, 1'b1, 8'h08);
    setf(8'h09);
    offer(16'h001B, 2'h3);
    setf(8'h01);
    offer(16'h0003, 2'h0);
    wb(A_PL, 1'b1, 8'h20);
    wb(A_PH, 1'b1, 8'h00);
    setf(8'h21);
    offer(16'h002B, 2'h1);
    setf(8'h0C);
    offer(16'h0013, 2'h0);
    setf(8'h00);
    wb(A_PL, 1'b1, 8'h04);
    ack_en <= 1'b1;
    setf(8'h02);
    take(16'h000B);
    setf(8'h06);
    take(16'h0013);
    setf(8'h07);
    no_req();
    setf(8'h00);
    reti();
    reti();
    wb(A_PL, 1'b1, 8'h00);
  endtask
  task t_event;
    wb(A_ST, 1'b1, 8'h3F);
    rchk("status cleared", A_ST, 8'h00);
    wb(A_MK, 1'b1, 8'h00);
    setf(8'h02);
    take(16'h000B);
    setf(8'h00);
    reti();
    rchk("status set", A_ST, 8'h02);
    chk("masked out", 16'h0000, {15'h0000, irq_out});
    wb(A_MK, 1'b1, 8'h02);
    repeat (2) @(negedge clk);
    chk("event out", 16'h0001, {15'h0000, irq_out});
    wb(A_ST, 1'b1, 8'h02);
    repeat (2) @(negedge clk);
    chk("event cleared", 16'h0000, {15'h0000, irq_out});
  endtask
  // ****************
  // run and verdict
  // ****************
  task summarize;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_regs();
    t_gate();
    t_vectors();
    t_prio();
    t_event();
    summarize();
  end
endmodule
